// ### logic/operand_field_pkg.sv
// Operand field decoder constants: field positions, widths, encodings.
// Assumes 16-bit instruction words presented by the fetch stage.
package operand_field_pkg;

  // Field positions within a 16-bit instruction word
  localparam int ACCESS_BIT_POS     = 8;
  localparam int DEST_BIT_POS       = 9;
  localparam int BIT_ADDR_LSB       = 9;
  localparam int BIT_ADDR_W         = 3;
  localparam int FILE_W             = 8;
  localparam int PTR_SEL_W          = 2;
  localparam int PTR_SEL_LSB        = 4;
  localparam int FAST_BIT_POS       = 0;
  localparam int TABLE_MODE_W       = 2;
  localparam int LONG_ADDR_W        = 12;
  localparam int OFFSET_W           = 7;
  localparam int OFFSET_SRC_LSB     = 0;
  localparam int OFFSET_DST_LSB     = 0;
  localparam int LIT8_W             = 8;
  localparam int LIT12_W            = 12;
  localparam int LIT20_W            = 20;
  localparam int REL_SHORT_W        = 8;
  localparam int REL_LONG_W         = 11;
  localparam int BANK_W             = 4;
  localparam int DATA_W             = 8;
  localparam int TABLE_PTR_W        = 21;
  localparam int INSN_W             = 16;

  // Access RAM bank used when the access bit is clear
  localparam logic [BANK_W-1:0]      ACCESS_BANK = 4'h0;
  localparam logic [TABLE_PTR_W-1:0] PTR_ONE     = 21'h000001;
  localparam logic [TABLE_PTR_W-1:0] PTR_RESET   = 21'h000000;
  localparam logic [DATA_W-1:0]      LATCH_RESET = 8'h00;

  // Operand format supplied by the opcode decoder
  typedef enum logic [3:0] {
    FMT_NONE,
    FMT_BYTE_FILE,
    FMT_BIT_FILE,
    FMT_PTR_LIT,
    FMT_LIT8,
    FMT_MOVE_LONG,
    FMT_MOVE_INDEXED,
    FMT_REL_SHORT,
    FMT_REL_LONG,
    FMT_ABS_TARGET,
    FMT_FAST_RET,
    FMT_TABLE
  } operand_format_t;

  // Table pointer mode field encodings
  typedef enum logic [1:0] {
    TBL_NO_CHANGE = 2'h0,
    TBL_POST_INC  = 2'h1,
    TBL_POST_DEC  = 2'h2,
    TBL_PRE_INC   = 2'h3
  } table_mode_t;

endpackage : operand_field_pkg

// ### logic/table_pointer_unit.sv
// Program-table pointer and table data latch with mode-driven update.
// Assumes one access request per cycle from the core sequencer.
module table_pointer_unit (
  // Clock and reset
  input  wire logic                                     i_clk_sys,
  input  wire logic                                     i_rst_n,
  // Access request
  input  wire logic                                     i_access,
  input  wire logic                                     i_is_write,
  input  wire logic [operand_field_pkg::TABLE_MODE_W-1:0] i_mode,
  input  wire logic                                     i_ptr_load,
  input  wire logic [operand_field_pkg::TABLE_PTR_W-1:0]  i_ptr_value,
  input  wire logic [operand_field_pkg::DATA_W-1:0]       i_read_data,
  input  wire logic [operand_field_pkg::DATA_W-1:0]       i_latch_value,
  input  wire logic                                     i_latch_load,
  // State
  output logic      [operand_field_pkg::TABLE_PTR_W-1:0]  o_program_table_pointer,
  output logic      [operand_field_pkg::TABLE_PTR_W-1:0]  o_access_address,
  output logic      [operand_field_pkg::DATA_W-1:0]       o_table_data_latch
);

  logic [operand_field_pkg::TABLE_PTR_W-1:0] ptr_inc;
  logic [operand_field_pkg::TABLE_PTR_W-1:0] ptr_dec;
  logic [operand_field_pkg::TABLE_PTR_W-1:0] next_ptr;
  logic [operand_field_pkg::DATA_W-1:0]      next_latch;
  wire  operand_field_pkg::table_mode_t      mode = operand_field_pkg::table_mode_t'(i_mode);

  assign ptr_inc = o_program_table_pointer + operand_field_pkg::PTR_ONE;
  assign ptr_dec = o_program_table_pointer - operand_field_pkg::PTR_ONE;

  // Pre-increment uses the bumped address for this access
  assign o_access_address = (mode == operand_field_pkg::TBL_PRE_INC) ? ptr_inc
                                                                      : o_program_table_pointer;

  always_comb begin
    next_ptr = o_program_table_pointer;
    if (i_ptr_load) begin
      next_ptr = i_ptr_value;
    end else if (i_access) begin
      case (mode)
        operand_field_pkg::TBL_NO_CHANGE: next_ptr = o_program_table_pointer;
        operand_field_pkg::TBL_POST_INC:  next_ptr = ptr_inc;
        operand_field_pkg::TBL_POST_DEC:  next_ptr = ptr_dec;
        operand_field_pkg::TBL_PRE_INC:   next_ptr = ptr_inc;
        default:                          next_ptr = o_program_table_pointer;
      endcase
    end
  end

  // Reads fill the latch; writes take their data from it
  assign next_latch = i_latch_load                 ? i_latch_value :
                      (i_access && !i_is_write)    ? i_read_data   : o_table_data_latch;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_program_table_pointer <= operand_field_pkg::PTR_RESET;
      o_table_data_latch      <= operand_field_pkg::LATCH_RESET;
    end else begin
      o_program_table_pointer <= next_ptr;
      o_table_data_latch      <= next_latch;
    end
  end

endmodule : table_pointer_unit

// ### logic/operand_field_decoder.sv
// Operand field decoder: splits instruction words into datapath operands.
// Assumes the opcode decoder supplies the operand format with each word.
// How it works
// - Access bit 0 uses access bank, else bank register
// - Destination bit picks working register or file
// - Three-bit field selects bit 0 to 7
// - File field: 8-bit address or pointer selector
// - Long moves carry 12-bit source and destination
// - Fast bit enables shadow save or restore
// - Table mode: none, post-inc, post-dec, pre-inc
// - Relative offsets signed; call targets direct
// - Table pointer 21 bits, table latch 8 bits
// - Literals decoded at 8, 12 or 20 bits
// - Indexed moves carry two 7-bit offsets
// - Don't-care bits are ignored by decoding
module operand_field_decoder (
  // Clock and reset
  input  wire logic                                        i_clk_sys,
  input  wire logic                                        i_rst_n,
  // Instruction from fetch
  input  wire logic                                        i_valid,
  input  wire logic [operand_field_pkg::INSN_W-1:0]          i_word0,
  input  wire logic [operand_field_pkg::INSN_W-1:0]          i_word1,
  input  wire logic [3:0]                                  i_format,
  input  wire logic                                        i_is_call,
  // Core state
  input  wire logic [operand_field_pkg::BANK_W-1:0]          i_bank_select_register,
  // Table access
  input  wire logic                                        i_table_write,
  input  wire logic                                        i_ptr_load,
  input  wire logic [operand_field_pkg::TABLE_PTR_W-1:0]     i_ptr_value,
  input  wire logic [operand_field_pkg::DATA_W-1:0]          i_table_read_data,
  input  wire logic                                        i_latch_load,
  input  wire logic [operand_field_pkg::DATA_W-1:0]          i_latch_value,
  // Register file operands
  output logic                                             o_valid,
  output logic      [operand_field_pkg::BANK_W-1:0]          o_bank,
  output logic      [operand_field_pkg::FILE_W-1:0]          o_file_addr,
  output logic      [operand_field_pkg::PTR_SEL_W-1:0]       o_pointer_select,
  output logic                                             o_pointer_select_valid,
  output logic                                             o_dest_working_register,
  output logic      [operand_field_pkg::DATA_W-1:0]          o_bit_mask,
  output logic      [operand_field_pkg::BIT_ADDR_W-1:0]      o_bit_index,
  // Moves
  output logic      [operand_field_pkg::LONG_ADDR_W-1:0]     o_src_addr,
  output logic      [operand_field_pkg::LONG_ADDR_W-1:0]     o_dst_addr,
  output logic      [operand_field_pkg::OFFSET_W-1:0]        o_src_offset,
  output logic      [operand_field_pkg::OFFSET_W-1:0]        o_dst_offset,
  // Literals and control flow
  output logic      [operand_field_pkg::LIT20_W-1:0]         o_literal,
  output logic                                             o_rel_branch,
  output logic      [operand_field_pkg::LIT20_W-1:0]         o_target,
  output logic                                             o_shadow_save,
  output logic                                             o_shadow_restore,
  // Table state
  output logic      [operand_field_pkg::TABLE_PTR_W-1:0]     o_program_table_pointer,
  output logic      [operand_field_pkg::TABLE_PTR_W-1:0]     o_table_access_address,
  output logic      [operand_field_pkg::DATA_W-1:0]          o_table_data_latch
);

  localparam int LW = operand_field_pkg::LIT20_W;

  operand_field_pkg::operand_format_t fmt;
  assign fmt = operand_field_pkg::operand_format_t'(i_format);

  wire is_byte  = (fmt == operand_field_pkg::FMT_BYTE_FILE);
  wire is_bit   = (fmt == operand_field_pkg::FMT_BIT_FILE);
  wire is_file  = is_byte | is_bit;
  wire is_ptr   = (fmt == operand_field_pkg::FMT_PTR_LIT);
  wire is_long  = (fmt == operand_field_pkg::FMT_MOVE_LONG);
  wire is_idx   = (fmt == operand_field_pkg::FMT_MOVE_INDEXED);
  wire is_rels  = (fmt == operand_field_pkg::FMT_REL_SHORT);
  wire is_rell  = (fmt == operand_field_pkg::FMT_REL_LONG);
  wire is_abs   = (fmt == operand_field_pkg::FMT_ABS_TARGET);
  wire is_fret  = (fmt == operand_field_pkg::FMT_FAST_RET);
  wire is_table = (fmt == operand_field_pkg::FMT_TABLE);

  // Field extraction; unused bits never enter any term
  wire access_bit = i_word0[operand_field_pkg::ACCESS_BIT_POS];
  wire dest_bit   = i_word0[operand_field_pkg::DEST_BIT_POS];
  wire fast_bit   = i_word0[operand_field_pkg::FAST_BIT_POS];
  wire [operand_field_pkg::BIT_ADDR_W-1:0] bit_field =
    i_word0[operand_field_pkg::BIT_ADDR_LSB +: operand_field_pkg::BIT_ADDR_W];
  wire [operand_field_pkg::FILE_W-1:0] file_field =
    i_word0[operand_field_pkg::FILE_W-1:0];
  wire [operand_field_pkg::PTR_SEL_W-1:0] ptr_field =
    i_word0[operand_field_pkg::PTR_SEL_LSB +: operand_field_pkg::PTR_SEL_W];
  wire [operand_field_pkg::TABLE_MODE_W-1:0] mode_field =
    i_word0[operand_field_pkg::TABLE_MODE_W-1:0];

  // Bank choice: access area ignores the bank register
  wire [operand_field_pkg::BANK_W-1:0] next_bank =
    access_bit ? i_bank_select_register : operand_field_pkg::ACCESS_BANK;

  wire [operand_field_pkg::DATA_W-1:0] next_mask =
    operand_field_pkg::DATA_W'(1) << bit_field;

  // Long moves: 12-bit source in first word, destination in second
  wire [operand_field_pkg::LONG_ADDR_W-1:0] long_src =
    i_word0[operand_field_pkg::LONG_ADDR_W-1:0];
  wire [operand_field_pkg::LONG_ADDR_W-1:0] long_dst =
    i_word1[operand_field_pkg::LONG_ADDR_W-1:0];

  // Indexed moves: 7-bit offsets in each word
  wire [operand_field_pkg::OFFSET_W-1:0] idx_src =
    i_word0[operand_field_pkg::OFFSET_SRC_LSB +: operand_field_pkg::OFFSET_W];
  wire [operand_field_pkg::OFFSET_W-1:0] idx_dst =
    i_word1[operand_field_pkg::OFFSET_DST_LSB +: operand_field_pkg::OFFSET_W];

  // Literal widths
  wire [LW-1:0] lit8  = LW'(i_word0[operand_field_pkg::LIT8_W-1:0]);
  wire [LW-1:0] lit12 = LW'({i_word0[operand_field_pkg::PTR_SEL_W+1:0],
                             i_word1[operand_field_pkg::LIT8_W-1:0]});
  wire [LW-1:0] lit20 = {i_word1[operand_field_pkg::LONG_ADDR_W-1:0],
                         i_word0[operand_field_pkg::LIT8_W-1:0]};

  // Relative displacements, sign extended
  wire [LW-1:0] rel_short = LW'($signed(i_word0[operand_field_pkg::REL_SHORT_W-1:0]));
  wire [LW-1:0] rel_long  = LW'($signed(i_word0[operand_field_pkg::REL_LONG_W-1:0]));

  wire [LW-1:0] next_literal = is_abs  ? lit20 :
                               is_ptr  ? lit12 : lit8;
  wire [LW-1:0] next_target  = is_rels ? rel_short :
                               is_rell ? rel_long  :
                               is_abs  ? lit20     : {LW{1'b0}};

  wire next_save    = i_valid & is_abs & i_is_call & fast_bit;
  wire next_restore = i_valid & is_fret & fast_bit;
  wire tbl_access   = i_valid & is_table;

  // Registered operand controls
  wire next_psel_valid = i_valid & is_ptr;
  wire next_dest_working_register  = is_byte & ~dest_bit;
  wire next_rel        = i_valid & (is_rels | is_rell);
  wire [operand_field_pkg::DATA_W-1:0] next_bit_mask = is_bit ? next_mask : '0;

  table_pointer_unit u_table (
    .i_clk_sys               (i_clk_sys),
    .i_rst_n                 (i_rst_n),
    .i_access                (tbl_access),
    .i_is_write              (i_table_write),
    .i_mode                  (mode_field),
    .i_ptr_load              (i_ptr_load),
    .i_ptr_value             (i_ptr_value),
    .i_read_data             (i_table_read_data),
    .i_latch_value           (i_latch_value),
    .i_latch_load            (i_latch_load),
    .o_program_table_pointer (o_program_table_pointer),
    .o_access_address        (o_table_access_address),
    .o_table_data_latch      (o_table_data_latch)
  );

  // Register file operands
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid                <= 1'b0;
      o_bank                 <= '0;
      o_file_addr            <= '0;
      o_pointer_select       <= '0;
      o_pointer_select_valid <= 1'b0;
    end else begin
      o_valid                <= i_valid;
      o_bank                 <= next_bank;
      o_file_addr            <= file_field;
      o_pointer_select       <= ptr_field;
      o_pointer_select_valid <= next_psel_valid;
    end
  end

  // Destination and bit position
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dest_working_register <= 1'b0;
      o_bit_mask              <= '0;
      o_bit_index             <= '0;
    end else begin
      o_dest_working_register <= next_dest_working_register;
      o_bit_mask              <= next_bit_mask;
      o_bit_index             <= bit_field;
    end
  end

  // Long move addresses
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_src_addr <= '0;
      o_dst_addr <= '0;
    end else begin
      o_src_addr <= long_src;
      o_dst_addr <= long_dst;
    end
  end

  // Indexed move offsets
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_src_offset <= '0;
      o_dst_offset <= '0;
    end else begin
      o_src_offset <= idx_src;
      o_dst_offset <= idx_dst;
    end
  end

  // Literal and branch target
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_literal    <= '0;
      o_rel_branch <= 1'b0;
      o_target     <= '0;
    end else begin
      o_literal    <= next_literal;
      o_rel_branch <= next_rel;
      o_target     <= next_target;
    end
  end

  // Shadow register control
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_shadow_save    <= 1'b0;
      o_shadow_restore <= 1'b0;
    end else begin
      o_shadow_save    <= next_save;
      o_shadow_restore <= next_restore;
    end
  end

endmodule : operand_field_decoder

// ### test/operand_field_decoder_chk.sv
// Concurrent checks on the operand field decoder ports.
// Assumes registered outputs one cycle after each sampled word.
module operand_field_decoder_chk (
  // Clock, reset and inputs
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        i_valid,
  input wire logic [15:0] i_word0,
  input wire logic [15:0] i_word1,
  input wire logic [3:0]  i_format,
  input wire logic [3:0]  i_bank_select_register,
  input wire logic        i_table_write,
  input wire logic        i_ptr_load,
  input wire logic [7:0]  i_table_read_data,
  input wire logic        i_latch_load,
  // Outputs
  input wire logic [3:0]  o_bank,
  input wire logic [7:0]  o_bit_mask,
  input wire logic [2:0]  o_bit_index,
  input wire logic [11:0] o_src_addr,
  input wire logic [11:0] o_dst_addr,
  input wire logic [19:0] o_literal,
  input wire logic        o_rel_branch,
  input wire logic [19:0] o_target,
  input wire logic        o_shadow_save,
  input wire logic        o_shadow_restore,
  input wire logic [20:0] o_program_table_pointer,
  input wire logic [20:0] o_table_access_address,
  input wire logic [7:0]  o_table_data_latch
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Word taken at the previous edge, out of reset
  logic       pv;
  logic [3:0] pf;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pv <= 1'b0;
      pf <= 4'h0;
    end else begin
      pv <= i_valid;
      pf <= i_format;
    end
  end
  a_bank_source: assert property (
    pv |-> o_bank == ($past(i_word0[8]) ? $past(i_bank_select_register) : 4'h0))
    else $error("bank source wrong");
  a_bit_mask: assert property (
    pv && pf == 4'h2 |-> o_bit_mask == 8'h01 << $past(i_word0[11:9])
      && o_bit_index == $past(i_word0[11:9])) else $error("bit mask wrong");
  a_long_move: assert property (
    pv && pf == 4'h5 |-> o_src_addr == $past(i_word0[11:0])
      && o_dst_addr == $past(i_word1[11:0])) else $error("long move wrong");
  a_shadow_restore: assert property (
    pv && pf == 4'ha |-> o_shadow_restore == $past(i_word0[0]) && !o_shadow_save)
    else $error("shadow restore wrong");
  a_pointer_mode: assert property (
    pv && pf == 4'hb && !$past(i_ptr_load) |-> o_program_table_pointer ==
      ($past(i_word0[1:0]) == 2'h2 ? $past(o_program_table_pointer) - 21'h1 :
       $past(i_word0[1:0]) == 2'h0 ? $past(o_program_table_pointer) :
       $past(o_program_table_pointer) + 21'h1)) else $error("pointer mode wrong");
  a_pre_increment: assert property (
    i_valid && i_format == 4'hb |-> o_table_access_address ==
      o_program_table_pointer + (i_word0[1:0] == 2'h3)) else $error("address wrong");
  a_latch_fill: assert property (
    pv && pf == 4'hb && !$past(i_latch_load) |-> o_table_data_latch ==
      ($past(i_table_write) ? $past(o_table_data_latch) : $past(i_table_read_data)))
    else $error("latch wrong");
  a_rel_signed: assert property (
    pv && pf == 4'h7 |-> o_rel_branch
      && o_target == {{12{$past(i_word0[7])}}, $past(i_word0[7:0])}) else $error("rel wrong");
  a_literal_wide: assert property (
    pv && pf == 4'h9 |-> !o_rel_branch && o_target == o_literal
      && o_literal == {$past(i_word1[11:0]), $past(i_word0[7:0])}) else $error("lit wrong");
  c_table: cover property (pv && pf == 4'hb && $past(i_word0[1:0]) == 2'h3);
  c_rel: cover property (pv && pf == 4'h8 && o_rel_branch);
  c_restore: cover property (o_shadow_restore);
endmodule : operand_field_decoder_chk

bind operand_field_decoder operand_field_decoder_chk u_chk (.i_clk_sys, .i_rst_n,
  .i_valid, .i_word0, .i_word1, .i_format, .i_bank_select_register, .i_table_write,
  .i_ptr_load, .i_table_read_data, .i_latch_load, .o_bank, .o_bit_mask, .o_bit_index,
  .o_src_addr, .o_dst_addr, .o_literal, .o_rel_branch, .o_target, .o_shadow_save,
  .o_shadow_restore, .o_program_table_pointer, .o_table_access_address,
  .o_table_data_latch);

// ### test/testbench.sv
// Self-checking bench for the operand field decoder.
// Assumes registered outputs one cycle after each sampled word.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_valid = 1'b0;
  logic [15:0] i_word0 = 16'h0000;
  logic [15:0] i_word1 = 16'h0000;
  logic [3:0]  i_format = 4'h0;
  logic        i_is_call = 1'b0;
  logic [3:0]  i_bank_select_register = 4'h0;
  logic        i_table_write = 1'b0;
  logic        i_ptr_load = 1'b0;
  logic [20:0] i_ptr_value = 21'h000000;
  logic [7:0]  i_table_read_data = 8'h00;
  logic        i_latch_load = 1'b0;
  logic [7:0]  i_latch_value = 8'h00;
  wire         o_valid, o_dest_working_register, o_pointer_select_valid, o_rel_branch;
  wire         o_shadow_save, o_shadow_restore;
  wire  [3:0]  o_bank;
  wire  [7:0]  o_file_addr, o_bit_mask, o_table_data_latch;
  wire  [1:0]  o_pointer_select;
  wire  [2:0]  o_bit_index;
  wire  [11:0] o_src_addr, o_dst_addr;
  wire  [6:0]  o_src_offset, o_dst_offset;
  wire  [19:0] o_literal, o_target;
  wire  [20:0] o_program_table_pointer, o_table_access_address;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;
  operand_field_decoder dut (.i_clk_sys, .i_rst_n, .i_valid, .i_word0, .i_word1,
    .i_format, .i_is_call, .i_bank_select_register, .i_table_write, .i_ptr_load,
    .i_ptr_value, .i_table_read_data, .i_latch_load, .i_latch_value,
    .o_valid, .o_bank, .o_file_addr, .o_pointer_select, .o_pointer_select_valid,
    .o_dest_working_register, .o_bit_mask, .o_bit_index, .o_src_addr, .o_dst_addr,
    .o_src_offset, .o_dst_offset, .o_literal, .o_rel_branch, .o_target, .o_shadow_save,
    .o_shadow_restore, .o_program_table_pointer, .o_table_access_address,
    .o_table_data_latch);
  always #5 i_clk_sys = ~i_clk_sys;
  // Hang guard
  always @(posedge i_clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic send(input logic [3:0] fmt, input logic [15:0] w0, input logic [15:0] w1);
    @(negedge i_clk_sys);
    i_valid = 1'b1;
    i_format = fmt;
    i_word0 = w0;
    i_word1 = w1;
    @(posedge i_clk_sys);
    #1;
  endtask : send
  task automatic t_bank;
    @(negedge i_clk_sys);
    i_bank_select_register = 4'h9;
    send(4'h1, 16'hfcff, 16'hffff);
    chk("bank", o_bank, 4'h0);
    chk("dest", o_dest_working_register, 1'b1);
    chk("file", o_file_addr, 8'hff);
    chk("valid", o_valid, 1'b1);
    send(4'h1, 16'h0300, 16'h0000);
    chk("bank", o_bank, 4'h9);
    chk("dest", o_dest_working_register, 1'b0);
    chk("file", o_file_addr, 8'h00);
    $display("test bank done");
  endtask : t_bank
  task automatic t_bits;
    for (int b = 0; b < 8; b++) begin
      send(4'h2, {4'hf, b[2:0], 1'b0, 8'h5a}, 16'h0000);
      chk("mask", o_bit_mask, 8'h01 << b);
      chk("index", o_bit_index, b[2:0]);
    end
    $display("test bits done");
  endtask : t_bits
  task automatic t_lits;
    send(4'h3, 16'h0035, 16'hffc7);
    chk("psel", o_pointer_select, 2'h3);
    chk("psel_v", o_pointer_select_valid, 1'b1);
    chk("lit12", o_literal, 20'h005c7);
    send(4'h4, 16'hff81, 16'h0000);
    chk("lit8", o_literal, 20'h00081);
    send(4'h9, 16'h00a5, 16'hf123);
    chk("lit20", o_literal, 20'h123a5);
    chk("abs", o_target, 20'h123a5);
    send(4'h5, 16'hffff, 16'h0000);
    chk("src", o_src_addr, 12'hfff);
    chk("dst", o_dst_addr, 12'h000);
    send(4'h6, 16'h807f, 16'h7f80);
    chk("src_off", o_src_offset, 7'h7f);
    chk("dst_off", o_dst_offset, 7'h00);
    $display("test literals done");
  endtask : t_lits
  task automatic t_branch;
    send(4'h7, 16'h0080, 16'h0000);
    chk("rel8", o_target, 20'hfff80);
    send(4'h8, 16'h0400, 16'h0000);
    chk("rel11", o_target, 20'hffc00);
    chk("rel", o_rel_branch, 1'b1);
    @(negedge i_clk_sys);
    i_is_call = 1'b1;
    send(4'h9, 16'h0001, 16'h0000);
    chk("save", o_shadow_save, 1'b1);
    send(4'h9, 16'h0000, 16'h0000);
    chk("save", o_shadow_save, 1'b0);
    send(4'ha, 16'h0001, 16'h0000);
    chk("restore", o_shadow_restore, 1'b1);
    send(4'ha, 16'h0000, 16'h0000);
    chk("restore", o_shadow_restore, 1'b0);
    $display("test branch done");
  endtask : t_branch
  task automatic t_table;
    logic [20:0] ptr;
    logic [7:0]  lat;
    chk("ptr_rst", o_program_table_pointer, 21'h000000);
    @(negedge i_clk_sys);
    i_valid = 1'b0;
    i_ptr_load = 1'b1;
    i_ptr_value = 21'h1fffff;
    @(negedge i_clk_sys);
    i_ptr_load = 1'b0;
    ptr = 21'h1fffff;
    lat = 8'h00;
    for (int m = 0; m < 4; m++) begin
      @(negedge i_clk_sys);
      i_valid = 1'b1;
      i_format = 4'hb;
      i_word0 = {14'h0000, m[1:0]};
      i_table_write = m[0];
      i_table_read_data = 8'h30 + m[7:0];
      #1;
      chk("addr", o_table_access_address, (m == 3) ? 21'(ptr + 21'h1) : ptr);
      @(posedge i_clk_sys);
      #1;
      ptr = (m == 2) ? ptr - 21'h1 : (m == 0) ? ptr : ptr + 21'h1;
      lat = m[0] ? lat : 8'h30 + m[7:0];
      chk("ptr", o_program_table_pointer, ptr);
      chk("latch", o_table_data_latch, lat);
    end
    // Core load of the latch beats a read in the same cycle
    @(negedge i_clk_sys);
    i_table_write = 1'b0;
    i_latch_load = 1'b1;
    i_latch_value = 8'hc3;
    @(posedge i_clk_sys);
    #1;
    chk("latch_load", o_table_data_latch, 8'hc3);
    @(negedge i_clk_sys);
    i_latch_load = 1'b0;
    i_valid = 1'b0;
    @(posedge i_clk_sys);
    #1;
    chk("valid", o_valid, 1'b0);
    chk("latch_hold", o_table_data_latch, 8'hc3);
    $display("test table done");
  endtask : t_table
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    t_bank();
    t_bits();
    t_lits();
    t_branch();
    t_table();
    summarize();
  end
endmodule : testbench
